//--- core/lvcfg_params.svh
// offsets, field positions, reset values of the lvds output config registers
// assumes inclusion by bare name from the register module
`ifndef LVCFG_PARAMS_SVH
`define LVCFG_PARAMS_SVH

`define LVCFG_ADDR_DRIVE_TERM   8'h15
`define LVCFG_ADDR_PHASE_SEL    8'h16
`define LVCFG_ADDR_REF_SEL      8'h18

`define LVCFG_RST_DRIVE_TERM    8'h00
`define LVCFG_RST_PHASE_SEL     8'h03
`define LVCFG_RST_REF_SEL       8'h00

`define LVCFG_MASK_DRIVE_TERM   8'h31
`define LVCFG_MASK_PHASE_SEL    8'h0f
`define LVCFG_MASK_REF_SEL      8'h40

`define LVCFG_TERM_LSB          4
`define LVCFG_TERM_MSB          5
`define LVCFG_DRIVE2X_BIT       0
`define LVCFG_REF_EXT_BIT       6
`define LVCFG_PHASE_MAX         4'ha
`define LVCFG_PHASE_180         4'h3

`endif

//--- core/lvcfg_pkg.sv
// types for the lvds output config registers
// assumes compilation ahead of every module that imports it
package lvcfg_pkg;
   typedef enum logic [1:0] {
      LVCFG_TERM_NONE,
      LVCFG_TERM_200,
      LVCFG_TERM_100,
      LVCFG_TERM_100B
   } lvcfg_term_t;
endpackage : lvcfg_pkg

//--- core/lvcfg_regs.sv
// lvds output configuration register bank: termination, drive, phase, ref
// assumes a serial-port engine delivering byte writes and reads at reg_addr_i
`timescale 1ns/1ps
`default_nettype none
`include "lvcfg_params.svh"

module lvcfg_regs
   import lvcfg_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   output lvcfg_term_t     term_sel_o,
   output logic            clk_drive_2x_o,
   output logic      [3:0] clk_phase_sel_o,
   output logic            ref_external_o
);

   logic [7:0] drive_term_q;
   logic [7:0] phase_sel_q;
   logic [7:0] ref_sel_q;
   logic [7:0] rdata_d;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         drive_term_q <= `LVCFG_RST_DRIVE_TERM;
      end else if (reg_wr_i && reg_addr_i == `LVCFG_ADDR_DRIVE_TERM) begin
         drive_term_q <= reg_wdata_i & `LVCFG_MASK_DRIVE_TERM;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         phase_sel_q <= `LVCFG_RST_PHASE_SEL;
      end else if (reg_wr_i && reg_addr_i == `LVCFG_ADDR_PHASE_SEL) begin
         phase_sel_q <= reg_wdata_i & `LVCFG_MASK_PHASE_SEL;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ref_sel_q <= `LVCFG_RST_REF_SEL;
      end else if (reg_wr_i && reg_addr_i == `LVCFG_ADDR_REF_SEL) begin
         ref_sel_q <= reg_wdata_i & `LVCFG_MASK_REF_SEL;
      end
   end

   always_comb begin
      case (reg_addr_i)
         `LVCFG_ADDR_DRIVE_TERM: rdata_d = drive_term_q;
         `LVCFG_ADDR_PHASE_SEL:  rdata_d = phase_sel_q;
         `LVCFG_ADDR_REF_SEL:    rdata_d = ref_sel_q;
         default:                rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end
   end

   // outputs follow the stored fields one cycle later, from flops
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         term_sel_o     <= LVCFG_TERM_NONE;
         clk_drive_2x_o <= 1'b0;
         ref_external_o <= 1'b0;
      end else begin
         term_sel_o     <= lvcfg_term_t'(
            drive_term_q[`LVCFG_TERM_MSB:`LVCFG_TERM_LSB]);
         clk_drive_2x_o <= drive_term_q[`LVCFG_DRIVE2X_BIT];
         ref_external_o <= ref_sel_q[`LVCFG_REF_EXT_BIT];
      end
   end

   // codes above 10 are undefined; hold the last legal phase instead
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         clk_phase_sel_o <= `LVCFG_PHASE_180;
      end else if (phase_sel_q[3:0] <= `LVCFG_PHASE_MAX) begin
         clk_phase_sel_o <= phase_sel_q[3:0];
      end
   end

   // per-register write strobes and the mapped-address decode, for checks
   logic wr_term;
   logic wr_phase;
   logic wr_ref;
   logic addr_mapped;

   assign wr_term     = reg_wr_i && reg_addr_i == `LVCFG_ADDR_DRIVE_TERM;
   assign wr_phase    = reg_wr_i && reg_addr_i == `LVCFG_ADDR_PHASE_SEL;
   assign wr_ref      = reg_wr_i && reg_addr_i == `LVCFG_ADDR_REF_SEL;
   assign addr_mapped = reg_addr_i == `LVCFG_ADDR_DRIVE_TERM
      || reg_addr_i == `LVCFG_ADDR_PHASE_SEL
      || reg_addr_i == `LVCFG_ADDR_REF_SEL;

   sequence s_phase_write;
      wr_phase && reg_wdata_i[3:0] <= `LVCFG_PHASE_MAX;
   endsequence

   sequence s_no_phase_write;
      !wr_phase ##1 !wr_phase;
   endsequence

   sequence s_term_write;
      wr_term ##1 1'b1;
   endsequence

   sequence s_ref_write;
      wr_ref ##1 1'b1;
   endsequence

   a_phase_reset: assert property (
      @(posedge sys_clk_i)
      !rst_n_i |=> phase_sel_q == `LVCFG_RST_PHASE_SEL
         && reg_rdata_o == 8'h00)
      else $error("phase register not 0x03 after reset");

   a_regs_reset: assert property (
      @(posedge sys_clk_i)
      !rst_n_i |=> ref_sel_q == `LVCFG_RST_REF_SEL
         && drive_term_q == `LVCFG_RST_DRIVE_TERM)
      else $error("reference or adjust register not at default");

   a_reset_outs: assert property (
      @(posedge sys_clk_i)
      !rst_n_i |=> term_sel_o == LVCFG_TERM_NONE && !clk_drive_2x_o
         && !ref_external_o && clk_phase_sel_o == `LVCFG_PHASE_180)
      else $error("outputs not at defaults after reset");

   a_phase_range: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_phase_sel_o <= `LVCFG_PHASE_MAX)
      else $error("phase output beyond code 10");

   a_phase_follow: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_phase_write ##1 !wr_phase
      |=> clk_phase_sel_o == $past(reg_wdata_i[3:0], 2))
      else $error("phase output did not follow write");

   a_phase_hold: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_phase && reg_wdata_i[3:0] > `LVCFG_PHASE_MAX
      |=> ##1 $stable(clk_phase_sel_o))
      else $error("phase output moved on an undefined code");

   a_phase_store: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_phase |=> phase_sel_q
         == ($past(reg_wdata_i) & `LVCFG_MASK_PHASE_SEL))
      else $error("phase register kept unused bits");

   a_phase_stable: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_no_phase_write |=> $stable(clk_phase_sel_o))
      else $error("phase changed without a write");

   a_term_follow: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_term_write |=> term_sel_o == lvcfg_term_t'($past(
         reg_wdata_i[`LVCFG_TERM_MSB:`LVCFG_TERM_LSB], 2)))
      else $error("termination output did not follow write");

   a_drive_follow: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_term_write |=> clk_drive_2x_o
         == $past(reg_wdata_i[`LVCFG_DRIVE2X_BIT], 2))
      else $error("drive doubling did not follow write");

   a_term_store: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_term |=> drive_term_q
         == ($past(reg_wdata_i) & `LVCFG_MASK_DRIVE_TERM))
      else $error("adjust register kept unused bits");

   a_term_stable: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !wr_term |=> ##1 $stable(term_sel_o)
         && $stable(clk_drive_2x_o))
      else $error("termination or drive moved without a write");

   a_ref_follow: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_ref_write |=> ref_external_o
         == $past(reg_wdata_i[`LVCFG_REF_EXT_BIT], 2))
      else $error("reference select did not follow write");

   a_ref_store: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_ref |=> ref_sel_q
         == ($past(reg_wdata_i) & `LVCFG_MASK_REF_SEL))
      else $error("reference register kept unused bits");

   a_ref_stable: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !wr_ref |=> ##1 $stable(ref_external_o))
      else $error("reference select moved without a write");

   a_unused_zero: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      reg_rd_i |=> (reg_rdata_o & ~($past(reg_addr_i) == 8'h15 ? 8'h31 :
         $past(reg_addr_i) == 8'h16 ? 8'h0f :
         $past(reg_addr_i) == 8'h18 ? 8'h40 : 8'h00)) == 8'h00)
      else $error("unused bits read nonzero");

   a_unmapped_read: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      reg_rd_i && !addr_mapped |=> reg_rdata_o == 8'h00)
      else $error("unmapped address read nonzero");

   a_unmapped_write: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      reg_wr_i && !addr_mapped |=> $stable(drive_term_q)
         && $stable(phase_sel_q) && $stable(ref_sel_q))
      else $error("unmapped write changed a register");

endmodule : lvcfg_regs

`default_nettype wire

//--- bench/lvcfg_host.sv
// host model driving the register port
// assumes the bench supplies the clock
`timescale 1ns/1ps
`default_nettype none
module lvcfg_host (
   input  wire logic       sys_clk_i,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o
);
   initial {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge sys_clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge sys_clk_i);
      rd_o <= 1'b0;
   endtask : rd
endmodule : lvcfg_host
`default_nettype wire

//--- bench/lvds_output_config_regs_tb.sv
// self-checking bench for lvcfg_regs
// assumes lvcfg_host drives the register port
`timescale 1ns/1ps
`default_nettype none
module lvds_output_config_regs_tb;
   import lvcfg_pkg::*;
   logic        [7:0] addr, wdata, rdata;
   logic              clk, rst_n, wr, rd, drv, rx;
   lvcfg_term_t       term;
   logic        [3:0] ph;
   int                fail_count = 0;
   int                tests_run = 0;
   int                cyc = 0;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   lvcfg_host host (.sys_clk_i(clk), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));
   lvcfg_regs dut (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .term_sel_o(term), .clk_drive_2x_o(drv), .clk_phase_sel_o(ph),
      .ref_external_o(rx));
   task automatic chk(input string n, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, e);
      host.rd(a);
      @(posedge clk);
      #1;
      chk("rdata", e, rdata);
   endtask : rdc
   task automatic wrw(input logic [7:0] a, d);
      host.wr(a, d);
      repeat (2) @(posedge clk);
      #1;
   endtask : wrw
   task automatic close_out;
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic t_dflt;
      #1;
      chk("out", 8'h03, {term, drv, rx, ph});
      rdc(8'h15, 8'h00);
      rdc(8'h16, 8'h03);
      rdc(8'h18, 8'h00);
      rdc(8'h17, 8'h00);
   endtask : t_dflt
   task automatic t_cfg;
      host.wr(8'h15, 8'hff);
      wrw(8'h18, 8'hff);
      chk("out", 8'hf3, {term, drv, rx, ph});
      rdc(8'h15, 8'h31);
      rdc(8'h18, 8'h40);
      for (int t = 0; t < 4; t++) begin
         wrw(8'h15, 8'(t * 16));
         chk("term", 8'(t), {6'h00, term});
      end
      chk("drv", 8'h00, {7'h00, drv});
   endtask : t_cfg
   task automatic t_ph;
      for (int i = 0; i < 12; i++) begin
         wrw(8'h16, 8'(i));
         chk("phase", (i > 10) ? 8'h0a : 8'(i), {4'h0, ph});
      end
      rdc(8'h16, 8'h0b);
   endtask : t_ph
   task automatic t_misc;
      wrw(8'h16, 8'hf5);
      chk("phase", 8'h05, {4'h0, ph});
      rdc(8'h16, 8'h05);
      wrw(8'h17, 8'hff);
      rdc(8'h17, 8'h00);
      rdc(8'h16, 8'h05);
      wrw(8'h15, 8'h01);
      chk("drv", 8'h01, {7'h00, drv});
      chk("phase", 8'h05, {4'h0, ph});
   endtask : t_misc
   task automatic t_rst;
      wrw(8'h16, 8'h07);
      chk("phase", 8'h07, {4'h0, ph});
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("rst", 8'h03, {term, drv, rx, ph});
      rdc(8'h16, 8'h03);
      rdc(8'h18, 8'h00);
   endtask : t_rst
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_dflt();
      t_cfg();
      t_ph();
      t_misc();
      t_rst();
      close_out();
   end
endmodule : lvds_output_config_regs_tb
`default_nettype wire
